// file: hyst_sampler_defs.vh
/*
 defines for the input hysteresis sampler: register offsets, field positions,
 reset values and timing counts. assumes a 125 MHz core clock.
*/
`ifndef HYST_SAMPLER_DEFS_VH
`define HYST_SAMPLER_DEFS_VH

`define CORE_CLK_HZ        125000000
`define ALT_RATE_HZ        2000
`define ALT_HALF_CYCLES    (`CORE_CLK_HZ / `ALT_RATE_HZ)
`define SETTLE_NS          2000
`define SETTLE_CYCLES      ((`SETTLE_NS * 125 + 999) / 1000)
`define PACE_DEF_CYCLES    32'h000004E2

`define NUM_IN             12
`define DAC_W              10
`define DAC_STEPS          1024

`define OFF_CTRL           12'h000
`define OFF_LOW_THR        12'h004
`define OFF_HIGH_THR       12'h008
`define OFF_SINGLE_THR     12'h00C
`define OFF_DATA           12'h010
`define OFF_STATUS         12'h014
`define OFF_PACE           12'h018

`define CTRL_ENABLE_BIT    0
`define CTRL_HYST_BIT      1
`define CTRL_BUFFERED_BIT  2

`define LOW_THR_RESET      10'h100
`define HIGH_THR_RESET     10'h2FF
`define SINGLE_THR_RESET   10'h000

`define DATA_IN_LSB        0
`define DATA_IN_MSB        11
`define DATA_OUT_LSB       12
`define DATA_OUT_MSB       23

`endif

// file: hyst_channel.v
/*
 one input channel's hysteresis combination of a low-level and a high-level read.
 assumes strobes are one-cycle pulses from the sampler's sequencer.
*/
`timescale 1ns/1ps
module hyst_channel (
   input  wire core_clk_i,
   input  wire rst_n_i,
   input  wire hyst_en_i,
   input  wire cmp_i,
   input  wire low_strobe_i,
   input  wire high_strobe_i,
   output reg  level_o
);
   reg low_read_q;

   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         low_read_q <= 1'b0;
         level_o    <= 1'b0;
      end else if (!hyst_en_i) begin
         if (low_strobe_i)
            level_o <= cmp_i;
      end else begin
         if (low_strobe_i)
            low_read_q <= cmp_i;
         if (high_strobe_i) begin
            // mixed reads keep the old value, so a dip shorter than a low slot is ignored
            if (low_read_q == cmp_i)
               level_o <= cmp_i;
         end
      end
   end
endmodule // hyst_channel

// file: input_hysteresis_sampler.v
/*
 input hysteresis sampler: apb register slave, threshold dac sequencer,
 twelve channel combiners and sample pacing.
 assumes comparator outputs are synchronous to core_clk_i and the dac
 settles within the settle time after its code changes.
*/
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "hyst_sampler_defs.vh"

// Behaviour
// - ground reference code spans 1024 steps
// - hysteresis off: one level, direct read
// - hysteresis on: alternate low and high levels
// - alternation at 2 kHz
// - sample comparators after each level switch
// - both reads equal give that value
// - low one, high zero holds output
// - high stays one unless low dip
// - reset thresholds 25 and 75 percent
// - two separate 10-bit threshold values
// - buffered mode paced by onboard clock
// - inputs bits 11:0, outputs bits 23:12
// - twelve independent input channels
module input_hysteresis_sampler (
   input  wire        core_clk_i,
   input  wire        rst_n_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   input  wire [11:0] cmp_i,
   output reg  [9:0]  dac_code_o,
   output reg         at_high_level_o,
   output reg  [11:0] output_channel_bits_o,
   output reg  [11:0] sample_word_o,
   output reg         sample_valid_o
);
   localparam ST_LOW_SETTLE  = 4'b0001;
   localparam ST_LOW_HOLD    = 4'b0010;
   localparam ST_HIGH_SETTLE = 4'b0100;
   localparam ST_HIGH_HOLD   = 4'b1000;

   reg  [3:0]  state_q;
   reg  [3:0]  state_d;
   reg  [17:0] tick_q;
   reg         ctrl_en_q;
   reg         ctrl_hyst_q;
   reg         ctrl_buf_q;
   reg  [9:0]  low_thr_code_q;
   reg  [9:0]  high_thr_code_q;
   reg  [9:0]  single_thr_code_q;
   reg  [31:0] pace_q;
   reg  [31:0] pace_cnt_q;
   reg         overrun_q;
   wire [11:0] input_channel_bits;
   wire        low_strobe;
   wire        high_strobe;
   wire        setup;
   wire        access;
   wire        wr_en;
   wire        rd_en;
   wire        pace_hit;
   reg  [31:0] rd_data;
   reg         addr_ok;

   function is_mapped;
      input [11:0] a;
      begin
         is_mapped = (a == `OFF_CTRL) || (a == `OFF_LOW_THR) || (a == `OFF_HIGH_THR) ||
                     (a == `OFF_SINGLE_THR) || (a == `OFF_DATA) || (a == `OFF_STATUS) ||
                     (a == `OFF_PACE);
      end
   endfunction

   // apb: one wait state, answer in the second access cycle
   assign setup  = psel_i && !penable_i;
   assign access = psel_i && penable_i && pready_o;
   assign wr_en  = access && pwrite_i && is_mapped(paddr_i);
   assign rd_en  = access && !pwrite_i && (paddr_i == `OFF_DATA);

   always @* begin
      rd_data = 32'h00000000;
      addr_ok = is_mapped(paddr_i);
      case (paddr_i)
         `OFF_CTRL: begin
            rd_data[`CTRL_ENABLE_BIT]   = ctrl_en_q;
            rd_data[`CTRL_HYST_BIT]     = ctrl_hyst_q;
            rd_data[`CTRL_BUFFERED_BIT] = ctrl_buf_q;
         end
         `OFF_LOW_THR:    rd_data[9:0] = low_thr_code_q;
         `OFF_HIGH_THR:   rd_data[9:0] = high_thr_code_q;
         `OFF_SINGLE_THR: rd_data[9:0] = single_thr_code_q;
         `OFF_DATA: begin
            rd_data[`DATA_IN_MSB:`DATA_IN_LSB]   = input_channel_bits;
            rd_data[`DATA_OUT_MSB:`DATA_OUT_LSB] = output_channel_bits_o;
         end
         `OFF_STATUS: begin
            rd_data[0] = at_high_level_o;
            rd_data[1] = overrun_q;
         end
         `OFF_PACE:       rd_data = pace_q;
         default:         rd_data = 32'h00000000;
      endcase
   end

   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end else begin
         pready_o  <= psel_i && penable_i && !pready_o;
         pslverr_o <= psel_i && penable_i && !pready_o && !addr_ok;
         if (psel_i && penable_i && !pready_o)
            prdata_o <= rd_data;
         else if (!psel_i)
            prdata_o <= 32'h00000000;
      end
   end

   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ctrl_en_q             <= 1'b0;
         ctrl_hyst_q           <= 1'b0;
         ctrl_buf_q            <= 1'b0;
         low_thr_code_q        <= `LOW_THR_RESET;
         high_thr_code_q       <= `HIGH_THR_RESET;
         single_thr_code_q     <= `SINGLE_THR_RESET;
         pace_q                <= `PACE_DEF_CYCLES;
         output_channel_bits_o <= 12'h000;
      end else if (wr_en) begin
         case (paddr_i)
            `OFF_CTRL: begin
               ctrl_en_q   <= pwdata_i[`CTRL_ENABLE_BIT];
               ctrl_hyst_q <= pwdata_i[`CTRL_HYST_BIT];
               ctrl_buf_q  <= pwdata_i[`CTRL_BUFFERED_BIT];
            end
            `OFF_LOW_THR:    low_thr_code_q    <= pwdata_i[9:0];
            `OFF_HIGH_THR:   high_thr_code_q   <= pwdata_i[9:0];
            `OFF_SINGLE_THR: single_thr_code_q <= pwdata_i[9:0];
            // bits 31:24 are ignored on purpose
            `OFF_DATA:       output_channel_bits_o <= pwdata_i[`DATA_OUT_MSB:`DATA_OUT_LSB];
            `OFF_PACE:       pace_q <= (pwdata_i == 32'h00000000) ? 32'h00000001 : pwdata_i;
            default:         pace_q <= pace_q;
         endcase
      end
   end

   // each level slot lasts one full 2 kHz period (62500 cycles); a read is taken once the dac settles
   assign low_strobe  = (state_q == ST_LOW_SETTLE) && (tick_q == (`SETTLE_CYCLES - 1));
   assign high_strobe = (state_q == ST_HIGH_SETTLE) && (tick_q == (`SETTLE_CYCLES - 1));

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_LOW_SETTLE:  if (low_strobe) state_d = ST_LOW_HOLD;
         ST_LOW_HOLD:    if (tick_q == (`ALT_HALF_CYCLES - 1) && ctrl_hyst_q)
                            state_d = ST_HIGH_SETTLE;
                         else if (tick_q == (`ALT_HALF_CYCLES - 1))
                            state_d = ST_LOW_SETTLE;
         ST_HIGH_SETTLE: if (high_strobe) state_d = ST_HIGH_HOLD;
         ST_HIGH_HOLD:   if (tick_q == (`ALT_HALF_CYCLES - 1) || !ctrl_hyst_q)
                            state_d = ST_LOW_SETTLE;
         default:        state_d = ST_LOW_SETTLE;
      endcase
   end

   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_q         <= ST_LOW_SETTLE;
         tick_q          <= 18'h00000;
         dac_code_o      <= `SINGLE_THR_RESET;
         at_high_level_o <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_d != state_q && (state_d == ST_LOW_SETTLE || state_d == ST_HIGH_SETTLE))
            tick_q <= 18'h00000;
         else if (tick_q != (`ALT_HALF_CYCLES - 1))
            tick_q <= tick_q + 18'h00001;
         else
            tick_q <= 18'h00000;
         if (!ctrl_hyst_q)
            dac_code_o <= single_thr_code_q;
         else if (state_d == ST_HIGH_SETTLE || state_d == ST_HIGH_HOLD)
            dac_code_o <= high_thr_code_q;
         else
            dac_code_o <= low_thr_code_q;
         at_high_level_o <= ctrl_hyst_q && (state_d == ST_HIGH_SETTLE || state_d == ST_HIGH_HOLD);
      end
   end

   genvar g;
   generate
      for (g = 0; g < `NUM_IN; g = g + 1) begin : g_chan
         hyst_channel u_chan (
            .core_clk_i    (core_clk_i),
            .rst_n_i       (rst_n_i),
            .hyst_en_i     (ctrl_hyst_q),
            .cmp_i         (cmp_i[g]),
            .low_strobe_i  (low_strobe),
            .high_strobe_i (high_strobe),
            .level_o       (input_channel_bits[g])
         );
      end
   endgenerate

   assign pace_hit = (pace_cnt_q >= pace_q - 32'h00000001);

   // buffered words are paced locally; simple mode takes one word per host data read
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pace_cnt_q     <= 32'h00000000;
         sample_word_o  <= 12'h000;
         sample_valid_o <= 1'b0;
         overrun_q      <= 1'b0;
      end else begin
         sample_valid_o <= 1'b0;
         if (!ctrl_en_q) begin
            pace_cnt_q <= 32'h00000000;
         end else if (ctrl_buf_q) begin
            if (pace_hit) begin
               pace_cnt_q     <= 32'h00000000;
               sample_word_o  <= input_channel_bits;
               sample_valid_o <= 1'b1;
            end else begin
               pace_cnt_q <= pace_cnt_q + 32'h00000001;
            end
         end else if (rd_en) begin
            sample_word_o  <= input_channel_bits;
            sample_valid_o <= 1'b1;
         end
         // a status read clears overrun, but a new rate change in that cycle wins
         if (wr_en && paddr_i == `OFF_PACE && ctrl_buf_q)
            overrun_q <= 1'b1;
         else if (access && !pwrite_i && paddr_i == `OFF_STATUS)
            overrun_q <= 1'b0;
      end
   end
endmodule // input_hysteresis_sampler

// file: hyst_cmp_model.sv
/* comparator bank model: each channel's input is a 10-bit level code.
   assumes the dac code is the ground reference; no settling delay. */
`timescale 1ns/1ps
module hyst_cmp_model (
   input  wire logic [9:0]   dac_code_i,
   input  wire logic [119:0] level_i,
   output logic      [11:0]  cmp_o
);
   // a level equal to the reference reads zero, like a real comparator near its trip point
   always_comb begin
      for (int k = 0; k < 12; k++) begin
         cmp_o[k] = level_i[k*10 +: 10] > dac_code_i;
      end
   end
endmodule // hyst_cmp_model

// file: input_hysteresis_sampler_props.sv
/* checker for the sampler's apb, output word and level sequencing ports.
   assumes a 125 MHz clock and the defs header on the include path. */
`timescale 1ns/1ps
`include "hyst_sampler_defs.vh"
module input_hysteresis_sampler_props (
   input wire logic        core_clk_i,
   input wire logic        rst_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic [11:0] cmp_i,
   input wire logic [9:0]  dac_code_o,
   input wire logic        at_high_level_o,
   input wire logic [11:0] output_channel_bits_o,
   input wire logic [11:0] sample_word_o,
   input wire logic        sample_valid_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic        lvl_q;
   logic [16:0] gap_q;
   wire         wr_data = psel_i && penable_i && pwrite_i && pready_o && !pslverr_o && paddr_i == `OFF_DATA;
   // gap saturates so a long hysteresis-off stretch cannot wrap it
   always_ff @(posedge core_clk_i) begin
      lvl_q <= at_high_level_o;
      if (!rst_n_i || lvl_q != at_high_level_o)
         gap_q <= 17'h00000;
      else if (gap_q != 17'h1FFFF)
         gap_q <= gap_q + 17'h00001;
   end
   chk_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("pready held past one cycle");
   chk_wait_state: assert property (psel_i && penable_i && !$past(penable_i) |=> pready_o)
      else $error("pready not after one wait state");
   chk_err_ready: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");
   chk_idle_data: assert property (!psel_i && !$past(psel_i) |-> prdata_o == 32'h00000000)
      else $error("read data not zero while idle");
   chk_out_write: assert property (wr_data |=> output_channel_bits_o == $past(pwdata_i[23:12]))
      else $error("output bits not taken from bits 23 to 12");
   chk_out_stable: assert property (!$past(wr_data) |-> $stable(output_channel_bits_o))
      else $error("output bits moved without a data write");
   chk_slot_len: assert property ($rose(at_high_level_o) |-> gap_q >= 17'h0F3C0)
      else $error("reference switched to high too early");
   chk_valid_pulse: assert property (sample_valid_o |=> !sample_valid_o)
      else $error("sample valid longer than one cycle");
   cover property (wr_data);
   cover property ($rose(at_high_level_o));
   cover property (pslverr_o);
   cover property (sample_valid_o);
endmodule // input_hysteresis_sampler_props

bind input_hysteresis_sampler input_hysteresis_sampler_props props_i (.*);

// file: tb_input_hysteresis_sampler.sv
/* self-checking bench for the input hysteresis sampler.
   assumes the defs header, comparator model and checker are compiled first. */
`timescale 1ns/1ps
`include "hyst_sampler_defs.vh"
module tb_input_hysteresis_sampler;
   logic         core_clk_i = 1'b0;
   logic         rst_n_i    = 1'b0;
   logic         psel_i     = 1'b0;
   logic         penable_i  = 1'b0;
   logic         pwrite_i   = 1'b0;
   logic [11:0]  paddr_i    = 12'h000;
   logic [31:0]  pwdata_i   = 32'h00000000;
   logic [31:0]  prdata_o, rd;
   logic         pready_o, pslverr_o, at_high_level_o, sample_valid_o, er;
   logic [11:0]  cmp_i, output_channel_bits_o, sample_word_o;
   logic [9:0]   dac_code_o;
   // ch9-11 low, ch6-8 between thresholds, ch3-5 low, ch0-2 high
   logic [119:0] level = {30'h0, {3{10'h200}}, 30'h0, {3{10'h3FF}}};
   int           bad_count, checks_done, cyc, n;
   // time of the last bus release, so a back-to-back call lets one edge pass first
   realtime      rel_t = -1.0;
   always #4 core_clk_i = ~core_clk_i;
   input_hysteresis_sampler dut (.*);
   hyst_cmp_model cmp_m (.dac_code_i(dac_code_o), .level_i(level), .cmp_o(cmp_i));
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      if ($realtime == rel_t)
         @(posedge core_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 50);
      if (pready_o !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %0t no pready on bus transfer", $time);
      end
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      rel_t = $realtime;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_valid;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (sample_valid_o !== 1'b1 && n < 100);
      if (sample_valid_o !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %0t no sample valid pulse", $time);
      end
   endtask
   // the slot length is fixed, so the ceiling covers one full low slot
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         bad_count++;
         close_out();
      end
   end
   initial begin
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      xfer(1'b1, `OFF_CTRL, 32'h00000003);
      repeat (3) @(posedge core_clk_i);
      check({22'h0, dac_code_o}, 32'h00000100);
      xfer(1'b0, `OFF_LOW_THR, 32'h0);
      check(rd, 32'h00000100);
      xfer(1'b0, `OFF_HIGH_THR, 32'h0);
      check(rd, 32'h000002FF);
      xfer(1'b0, 12'h01C, 32'h0);
      check({31'h0, er}, 32'h00000001);
      xfer(1'b1, `OFF_DATA, 32'hFFABC000);
      @(posedge core_clk_i);
      check({20'h0, output_channel_bits_o}, 32'h00000ABC);
      $display("setup test done");
      n = 0;
      while (at_high_level_o !== 1'b1 && n < 70000) begin
         @(posedge core_clk_i);
         n++;
      end
      // ch9-11 rise only after their low read, giving the zero-then-one case
      level[119:90] <= {3{10'h3FF}};
      check({22'h0, dac_code_o}, 32'h000002FF);
      repeat (300) @(posedge core_clk_i);
      xfer(1'b0, `OFF_DATA, 32'h0);
      check(rd, 32'h00ABC007);
      wait_valid();
      check({31'h0, n <= 3}, 32'h00000001);
      $display("hysteresis test done");
      xfer(1'b1, `OFF_PACE, 32'h00000008);
      xfer(1'b1, `OFF_CTRL, 32'h00000007);
      wait_valid();
      wait_valid();
      check(n, 32'h00000008);
      check({20'h0, sample_word_o}, 32'h00000007);
      $display("buffered test done");
      close_out();
   end
endmodule // tb_input_hysteresis_sampler
